// ===== etc_mem_model.sv
// Purpose: memory partner of the transfer controller
// Assumes: 4 kbyte ram, higher address bits alias
// Notes:   slow adds three wait cycles; byte lanes not merged
`timescale 1ns/100ps
`default_nettype none
module etc_mem_model
  import etc_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire logic     slow,
  input  wire mem_req_s mem,
  output logic [31:0]   mem_rdata,
  output logic          mem_ack
);
  logic [31:0] ram [1024];
  logic [31:0] word_w;
  logic [31:0] junk_q;
  logic [1:0]  wait_q;
  logic [15:0] hi_q;
  int          n_wr;
  // ----
  // answer
  // ----
  // idle data toggles so a late sample never looks valid
  assign word_w    = ram[mem.addr[11:2]];
  assign mem_ack   = mem.req && wait_q == (slow ? 2'h3 : 2'h0);
  assign mem_rdata = !mem_ack ? junk_q
                   : mem.size != SZ_HALF ? word_w
                   : {16'h0000, mem.addr[1] ? word_w[15:0] : word_w[31:16]};
  // ----
  // state
  // ----
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wait_q <= 2'h0;
      junk_q <= 32'h5a5a_a5a5;
      hi_q   <= 16'h0000;
      n_wr   <= 0;
    end
    else
    begin
      junk_q <= ~junk_q;
      wait_q <= (mem.req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      if (mem_ack && mem.addr[31:16] != 16'h0000)
        hi_q <= mem.addr[31:16];
      if (mem_ack && mem.we)
      begin
        ram[mem.addr[11:2]] <= mem.wdata;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule : etc_mem_model
`default_nettype wire

// ===== etc_pick.sv
// Purpose: fixed priority pick of pending activation sources
// Assumes: index 0 is the lowest vector address
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module etc_pick
  import etc_pkg::*;
(
  input  wire logic [NSRC-1:0] pending,
  output logic                 found,
  output logic [4:0]           idx
);
  always_comb
  begin
    found = 1'b0;
    idx   = 5'h00;
    // scan downward so the lowest index wins
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        found = 1'b1;
        idx   = 5'(i);
      end
    end
  end
endmodule : etc_pick
`default_nettype wire

// ===== etc_pkg.sv
// Purpose: shared constants and types of the event transfer controller
// Assumes: 32 activation sources, Avalon-MM word index for registers
// Notes:   descriptor is four 32-bit words, big-endian halves
package etc_pkg;
  // ----------------------------------------
  // register map (word index, byte = 4*index)
  // ----------------------------------------
  localparam logic [1:0]  REG_CSW   = 2'h0;
  localparam logic [1:0]  REG_BASE  = 2'h1;
  localparam logic [1:0]  REG_ENA   = 2'h2;
  localparam logic [1:0]  REG_STAT  = 2'h3;
  localparam int          CSW_ABORT = 10;
  localparam int          CSW_AERR  = 9;
  localparam int          CSW_SOFT  = 8;
  localparam logic [15:0] BASE_RST  = 16'h0000;
  localparam logic [31:0] ENA_RST   = 32'h0000_0000;
  // ----------------------------------------
  // memory layout
  // ----------------------------------------
  localparam int          NSRC      = 32;
  localparam logic [15:0] VEC_BASE  = 16'h0400;
  localparam logic [31:0] DESC_SIZE = 32'h0000_0010;
  localparam logic [1:0]  SZ_HALF   = 2'h1;
  localparam logic [1:0]  SZ_WORD   = 2'h2;
  localparam logic [16:0] BLK_FULL  = 17'h1_0000;

  typedef enum logic [1:0] {
    XFER_NORMAL = 2'b00,
    XFER_REPEAT = 2'b01,
    XFER_BLOCK  = 2'b10,
    XFER_BAD    = 2'b11
  } xfer_mode_e;

  // mode word, msb first
  typedef struct packed {
    logic [1:0] src_step;
    logic [1:0] dst_step;
    xfer_mode_e md;
    logic [1:0] unit_size;
    logic       area_side_select;
    logic       chain_enable;
    logic       per_transfer_irq_select;
    logic       abort_continue;
    logic [3:0] unused;
  } mode_word_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;
endpackage : etc_pkg

// ===== etc_step.sv
// Purpose: pointer step after one unit
// Assumes: step code 0x holds, 10 adds, 11 subtracts
// Notes:   size 11 treated as longword
`timescale 1ns/100ps
`default_nettype none
module etc_step
  import etc_pkg::*;
(
  input  wire logic [31:0] ptr,
  input  wire logic [1:0]  step,
  input  wire logic [1:0]  unit_size,
  output logic [31:0]      next
);
  logic [31:0] amount;
  always_comb
  begin
    amount = (unit_size == 2'h0) ? 32'h1 : (unit_size == 2'h1) ? 32'h2 : 32'h4;
    unique case (step)
      2'b10:   next = ptr + amount;
      2'b11:   next = ptr - amount;
      default: next = ptr;
    endcase
  end
endmodule : etc_step
`default_nettype wire

// ===== event_data_transfer_ctrl.sv
// Purpose: interrupt or software started descriptor transfer controller
// Assumes: mem port holds request until mem_ack; Avalon word addressing
// Notes:   hardware sources always outrank the software start
// How it works
// - abort/address-error cleared by zero after read-one
// - soft start: one anytime, zero after read-one
// - base register gives upper address half
// - start by interrupt or software; enable routes
// - at end clear source flag or enable
// - activation ignores CPU mask and priorities
// - simultaneous sources served lowest vector first
// - descriptor address is base plus vector entry
// - descriptor layout differs per transfer mode
// - each source owns two-byte vector entry
// - software vector read at 0x400 plus select
// - read vector first, then descriptor words
// - write back descriptor; pointers step independently
// - normal: one unit, count minus one
// - repeat: reload count byte and repeat pointer
// - repeat never ends count, no end interrupt
// - block: restore block-side pointer, length kept
// - block count per block, interrupt at end
// - chain enable reads next consecutive descriptor
// - chained descriptor raises nothing, flag untouched
// - mode field 00 normal, 01 repeat, 10 block
// - step by 1, 2 or 4; 0x holds
// - per-transfer select interrupts after every transfer
// - address error or abort blocks all starts
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module event_data_transfer_ctrl
  import etc_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [1:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic [NSRC-1:0] irq_req,
  input  wire logic            abort_event,
  output logic [NSRC-1:0]      irq_to_cpu,
  output logic                 src_flag_clear,
  output logic [4:0]           src_flag_idx,
  output logic                 soft_end_irq,
  output mem_req_s             mem,
  input  wire logic [31:0]     mem_rdata,
  input  wire logic            mem_ack
);
  typedef enum {ST_IDLE, ST_VEC, ST_DESC, ST_DRD, ST_DWR, ST_WB, ST_FIN} state_e;

  state_e          st_q;
  logic            ack_q, abort_q, aerr_q, soft_q;
  logic            seen_abort_q, seen_aerr_q, seen_soft_q;
  logic [7:0]      soft_vector_select_q;
  logic [15:0]     base_q;
  logic [NSRC-1:0] ena_q;
  logic [31:0]     avs_readdata_q;
  logic [31:0]     desc_q, rpt_q, src_q, dst_q, src_init_q, dst_init_q, data_q;
  mode_word_s      mode_q;
  logic [15:0]     count_q;
  logic [16:0]     blk_left_q;
  logic [1:0]      widx_q;
  logic [4:0]      idx_q;
  logic            sw_q, end_q, soft_done_q;
  logic            found;
  logic [4:0]      pick_idx;
  logic [31:0]     src_next, dst_next;
  logic            bus_wr, bus_rd, go_ok, finish, raise;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // one wait cycle keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = avs_readdata_q;
  assign bus_wr          = avs_write & ack_q;
  assign bus_rd          = avs_read & ack_q;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      avs_readdata_q <= 32'h0;
    else if (avs_read & ~ack_q)
      unique case (avs_address)
        REG_CSW:  avs_readdata_q <= {21'h0, abort_q, aerr_q, soft_q, soft_vector_select_q};
        REG_BASE: avs_readdata_q <= {16'h0, base_q};
        REG_ENA:  avs_readdata_q <= ena_q;
        REG_STAT: avs_readdata_q <= {26'h0, idx_q, st_q != ST_IDLE};
      endcase

  // read-one arming for the clear-by-zero bits
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      seen_abort_q <= 1'b0;
      seen_aerr_q  <= 1'b0;
      seen_soft_q  <= 1'b0;
    end
    else if (bus_rd && avs_address == REG_CSW)
    begin
      seen_abort_q <= abort_q;
      seen_aerr_q  <= aerr_q;
      seen_soft_q  <= soft_q;
    end

  // hardware set wins over a clearing write
  always_ff @(posedge clock or posedge rst)
    if (rst)
      abort_q <= 1'b0;
    else if (abort_event)
      abort_q <= 1'b1;
    else if (bus_wr && avs_address == REG_CSW && !avs_writedata[CSW_ABORT] && seen_abort_q)
      abort_q <= 1'b0;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      aerr_q <= 1'b0;
    else if (st_q == ST_VEC && mem_ack && mem_rdata[1:0] != 2'b00)
      aerr_q <= 1'b1;
    else if (bus_wr && avs_address == REG_CSW && !avs_writedata[CSW_AERR] && seen_aerr_q)
      aerr_q <= 1'b0;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      soft_q <= 1'b0;
    else if (bus_wr && avs_address == REG_CSW && avs_writedata[CSW_SOFT])
      soft_q <= 1'b1;
    else if (bus_wr && avs_address == REG_CSW && seen_soft_q)
      soft_q <= 1'b0;
    else if (finish && sw_q && !mode_q.chain_enable && !raise)
      soft_q <= 1'b0;

  // a served start that raises soft_end_irq keeps the bit set; without this it would restart forever
  always_ff @(posedge clock or posedge rst)
    if (rst)
      soft_done_q <= 1'b0;
    else if (finish && sw_q && !mode_q.chain_enable && raise)
      soft_done_q <= 1'b1;
    else if (!soft_q)
      soft_done_q <= 1'b0;

  // vector select frozen while a software start is armed
  always_ff @(posedge clock or posedge rst)
    if (rst)
      soft_vector_select_q <= 8'h00;
    else if (bus_wr && avs_address == REG_CSW && !soft_q)
      soft_vector_select_q <= avs_writedata[7:0];

  // a byte write is ignored; software must enable both low byte lanes
  always_ff @(posedge clock or posedge rst)
    if (rst)
      base_q <= BASE_RST;
    else if (bus_wr && avs_address == REG_BASE && avs_byteenable[1:0] == 2'b11)
      base_q <= avs_writedata[15:0];

  always_ff @(posedge clock or posedge rst)
    if (rst)
      ena_q <= ENA_RST;
    else if (bus_wr && avs_address == REG_ENA)
      ena_q <= avs_writedata;
    else if (finish && !sw_q && !mode_q.chain_enable && raise)
      ena_q[idx_q] <= 1'b0;

  // ----------------------------------------
  // activation
  // ----------------------------------------
  // enabled sources bypass the CPU entirely, mask level not consulted
  assign irq_to_cpu = irq_req & ~ena_q;
  assign go_ok      = !abort_q && !aerr_q;

  etc_pick u_pick (
    .pending (irq_req & ena_q),
    .found   (found),
    .idx     (pick_idx)
  );

  etc_step u_src_step (
    .ptr       (src_q),
    .step      (mode_q.src_step),
    .unit_size (mode_q.unit_size),
    .next      (src_next)
  );

  etc_step u_dst_step (
    .ptr       (dst_q),
    .step      (mode_q.dst_step),
    .unit_size (mode_q.unit_size),
    .next      (dst_next)
  );

  assign finish = (st_q == ST_FIN);
  assign raise  = mode_q.per_transfer_irq_select | end_q;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      st_q   <= ST_IDLE;
      widx_q <= 2'h0;
      idx_q  <= 5'h00;
      sw_q   <= 1'b0;
      desc_q <= 32'h0;
    end
    else
      unique case (st_q)
        ST_IDLE:
          if (go_ok && found)
          begin
            st_q  <= ST_VEC;
            idx_q <= pick_idx;
            sw_q  <= 1'b0;
          end
          else if (go_ok && soft_q && !soft_done_q)
          begin
            st_q <= ST_VEC;
            sw_q <= 1'b1;
          end
        ST_VEC:
          if (mem_ack)
          begin
            desc_q <= {base_q, mem_rdata[15:0]};
            widx_q <= 2'h0;
            st_q   <= (mem_rdata[1:0] != 2'b00) ? ST_IDLE : ST_DESC;
          end
        ST_DESC:
          if (mem_ack)
          begin
            widx_q <= widx_q + 2'h1;
            if (widx_q == 2'h3)
              st_q <= ST_DRD;
          end
        ST_DRD:
          if (mem_ack)
            st_q <= ST_DWR;
        ST_DWR:
          if (mem_ack)
          begin
            widx_q <= 2'h0;
            st_q   <= (mode_q.md == XFER_BLOCK && blk_left_q != 17'h1) ? ST_DRD : ST_WB;
          end
        ST_WB:
          if (mem_ack)
          begin
            // word 1 (gap, repeat pointer, block length) is never written
            widx_q <= (widx_q == 2'h0) ? 2'h2 : 2'h3;
            if (widx_q == 2'h3)
              st_q <= ST_FIN;
          end
        ST_FIN:
          if (mode_q.chain_enable)
          begin
            desc_q <= desc_q + DESC_SIZE;
            widx_q <= 2'h0;
            st_q   <= ST_DESC;
          end
          else
            st_q <= ST_IDLE;
      endcase

  // ----------------------------------------
  // descriptor and data path
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      mode_q     <= '0;
      count_q    <= 16'h0;
      rpt_q      <= 32'h0;
      src_q      <= 32'h0;
      dst_q      <= 32'h0;
      src_init_q <= 32'h0;
      dst_init_q <= 32'h0;
      data_q     <= 32'h0;
      blk_left_q <= 17'h0;
      end_q      <= 1'b0;
    end
    else if (mem_ack)
      unique case (st_q)
        ST_DESC:
          unique case (widx_q)
            2'h0:
            begin
              mode_q  <= mode_word_s'(mem_rdata[31:16]);
              count_q <= mem_rdata[15:0];
            end
            2'h1:
            begin
              rpt_q      <= mem_rdata;
              blk_left_q <= (mem_rdata[15:0] == 16'h0) ? BLK_FULL : {1'b0, mem_rdata[15:0]};
            end
            2'h2:
            begin
              src_q      <= mem_rdata;
              src_init_q <= mem_rdata;
            end
            2'h3:
            begin
              dst_q      <= mem_rdata;
              dst_init_q <= mem_rdata;
            end
          endcase
        ST_DRD:
          data_q <= mem_rdata;
        ST_DWR:
        begin
          src_q      <= src_next;
          dst_q      <= dst_next;
          blk_left_q <= blk_left_q - 17'h1;
          end_q      <= (mode_q.md != XFER_REPEAT) && count_q == 16'h1;
          if (mode_q.md == XFER_REPEAT)
          begin
            if (count_q[7:0] == 8'h01)
            begin
              count_q[7:0] <= count_q[15:8];
              if (mode_q.area_side_select)
                src_q <= rpt_q;
              else
                dst_q <= rpt_q;
            end
            else
              count_q[7:0] <= count_q[7:0] - 8'h01;
          end
          else if (mode_q.md == XFER_BLOCK)
          begin
            if (blk_left_q == 17'h1)
            begin
              count_q <= count_q - 16'h1;
              if (mode_q.area_side_select)
                src_q <= src_init_q;
              else
                dst_q <= dst_init_q;
            end
          end
          else
            count_q <= count_q - 16'h1;
        end
        default:
          data_q <= data_q;
      endcase

  // ----------------------------------------
  // memory request
  // ----------------------------------------
  always_comb
  begin
    mem = '0;
    unique case (st_q)
      ST_VEC:
      begin
        mem.req  = 1'b1;
        mem.size = SZ_HALF;
        // each source owns a two-byte entry upward from the table base
        mem.addr = {16'h0, VEC_BASE + (sw_q ? {8'h0, soft_vector_select_q} : {10'h0, idx_q, 1'b0})};
      end
      ST_DESC:
      begin
        mem.req  = 1'b1;
        mem.size = SZ_WORD;
        mem.addr = desc_q + {28'h0, widx_q, 2'b00};
      end
      ST_DRD:
      begin
        mem.req  = 1'b1;
        mem.size = mode_q.unit_size;
        mem.addr = src_q;
      end
      ST_DWR:
      begin
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.size  = mode_q.unit_size;
        mem.addr  = dst_q;
        mem.wdata = data_q;
      end
      ST_WB:
      begin
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.size  = SZ_WORD;
        mem.addr  = desc_q + {28'h0, widx_q, 2'b00};
        mem.wdata = (widx_q == 2'h0) ? {mode_q, count_q} : (widx_q == 2'h2) ? src_q : dst_q;
      end
      default:
        mem = '0;
    endcase
  end

  // ----------------------------------------
  // completion
  // ----------------------------------------
  assign src_flag_clear = finish && !sw_q && !mode_q.chain_enable && !raise;
  assign src_flag_idx   = idx_q;
  assign soft_end_irq   = finish && sw_q && !mode_q.chain_enable && raise;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_vec_done;
    st_q == ST_VEC && mem_ack && mem_rdata[1:0] == 2'b00;
  endsequence
  sequence s_desc_start;
    st_q == ST_DESC && widx_q == 2'h0;
  endsequence

  property p_abort_clear;
    @(posedge clock) disable iff (rst) $fell(abort_q) |-> $past(seen_abort_q);
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("abort flag cleared unarmed");
  property p_soft_clear;
    @(posedge clock) disable iff (rst) $fell(soft_q) |-> $past(seen_soft_q) || $past(finish);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft start cleared unarmed");
  property p_blocked;
    @(posedge clock) disable iff (rst) (st_q == ST_IDLE && (abort_q || aerr_q)) |=> st_q == ST_IDLE;
  endproperty
  a_blocked: assert property (p_blocked) else $error("start while blocked");
  property p_desc_addr;
    @(posedge clock) disable iff (rst) s_vec_done |=> s_desc_start ##0 desc_q == {base_q, $past(mem_rdata[15:0])};
  endproperty
  a_desc_addr: assert property (p_desc_addr) else $error("bad descriptor address");
  property p_soft_vec;
    @(posedge clock) disable iff (rst) (st_q == ST_VEC && sw_q) |-> mem.addr == 32'h400 + soft_vector_select_q;
  endproperty
  a_soft_vec: assert property (p_soft_vec) else $error("bad software vector");
  property p_lowest;
    @(posedge clock) disable iff (rst) (st_q == ST_IDLE && go_ok && found)
      |=> (($past(irq_req & ena_q) & ((32'h1 << idx_q) - 32'h1)) == 32'h0);
  endproperty
  a_lowest: assert property (p_lowest) else $error("priority order broken");
  property p_chain_quiet;
    @(posedge clock) disable iff (rst) (finish && mode_q.chain_enable) |-> !src_flag_clear && !soft_end_irq;
  endproperty
  a_chain_quiet: assert property (p_chain_quiet) else $error("chained descriptor signalled");
  property p_repeat_quiet;
    @(posedge clock) disable iff (rst) (finish && mode_q.md == XFER_REPEAT && !mode_q.per_transfer_irq_select)
      |-> !raise;
  endproperty
  a_repeat_quiet: assert property (p_repeat_quiet) else $error("repeat mode raised interrupt");
endmodule : event_data_transfer_ctrl
`default_nettype wire

// ===== event_data_transfer_ctrl_bench.sv
// Purpose: self-checking bench of the transfer controller
// Assumes: descriptors at 0x100, base upper half 0x0001
// Notes:   sources clear their flag on the clear pulse
`timescale 1ns/100ps
`default_nettype none
module event_data_transfer_ctrl_bench
  import etc_pkg::*;
;
  logic            clock = 1'b0;
  logic            rst = 1'b1;
  logic [1:0]      avs_address = 2'h0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [3:0]      avs_byteenable = 4'hf;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [NSRC-1:0] irq_req = 32'h8000_0000;
  logic            abort_event = 1'b0;
  logic            slow = 1'b0;
  logic [NSRC-1:0] irq_to_cpu;
  logic            src_flag_clear;
  logic [4:0]      src_flag_idx;
  logic            soft_end_irq;
  mem_req_s        mem;
  logic [31:0]     mem_rdata;
  logic            mem_ack;
  logic [31:0]     q;
  logic [4:0]      idx_q [$];
  int              n_errors = 0;
  int              checks = 0;
  int              n_soft = 0;
  int              base_wr;
  typedef struct {
    logic [15:0] mode;
    logic [15:0] cnt;
    logic [31:0] w1;
    int          nwr;
    logic [15:0] ecnt;
    logic [31:0] esrc;
    logic [31:0] edst;
    logic        eena;
  } row_s;
  // source 0x200, destination 0x300 in every row
  row_s rows [9] = '{
    '{16'ha200, 16'h0002, 32'h0, 4, 16'h0001, 32'h204, 32'h304, 1'b1},
    '{16'h3000, 16'h0002, 32'h0, 4, 16'h0001, 32'h200, 32'h2ff, 1'b1},
    '{16'h9100, 16'h0002, 32'h0, 4, 16'h0001, 32'h202, 32'h300, 1'b1},
    '{16'ha200, 16'h0001, 32'h0, 4, 16'h0000, 32'h204, 32'h304, 1'b0},
    '{16'ha220, 16'h0005, 32'h0, 4, 16'h0004, 32'h204, 32'h304, 1'b0},
    '{16'ha600, 16'h0301, 32'h380, 4, 16'h0303, 32'h204, 32'h380, 1'b1},
    '{16'ha600, 16'h0302, 32'h380, 4, 16'h0301, 32'h204, 32'h304, 1'b1},
    '{16'haa80, 16'h0001, 32'h2, 5, 16'h0000, 32'h200, 32'h308, 1'b0},
    '{16'haa00, 16'h0002, 32'h2, 5, 16'h0001, 32'h208, 32'h300, 1'b1}
  };

  always #2.5 clock = ~clock;

  event_data_transfer_ctrl i_dut (
    .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_req, .abort_event,
    .irq_to_cpu, .src_flag_clear, .src_flag_idx, .soft_end_irq, .mem,
    .mem_rdata, .mem_ack
  );
  etc_mem_model i_mem (.clock, .rst, .slow, .mem, .mem_rdata, .mem_ack);

  // a source drops its flag when told to
  always @(posedge clock)
  begin
    if (src_flag_clear === 1'b1)
    begin
      irq_req[src_flag_idx] <= 1'b0;
      idx_q.push_back(src_flag_idx);
    end
    if (soft_end_irq === 1'b1)
      n_soft <= n_soft + 1;
  end
  // ----
  // tasks
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request held until waitrequest is sampled low at a rising edge; a hang ends at the watchdog
  task acc(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_read       <= !w;
    avs_write      <= w;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task wr(input logic [1:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask : wr

  task rdc(input logic [1:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask : rdc

  task desc(input int k, input logic [15:0] m, input logic [15:0] c, input logic [31:0] w1);
    i_mem.ram[k]   = {m, c};
    i_mem.ram[k+1] = w1;
    i_mem.ram[k+2] = 32'h200;
    i_mem.ram[k+3] = 32'h300;
  endtask : desc

  task wait_wr(input int n);
    int t;
    int k;
    t = i_mem.n_wr + n;
    k = 0;
    while (i_mem.n_wr < t && k < 400)
    begin
      @(posedge clock);
      k++;
    end
    chk(i_mem.n_wr, t);
    repeat (4) @(posedge clock);
  endtask : wait_wr

  task fire(input logic [31:0] bits, input int n);
    wr(REG_ENA, bits);
    irq_req <= irq_req | bits;
    wait_wr(n);
  endtask : fire

  task end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ----
  // sequence
  // ----
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    i_mem.ram[256] = 32'h0100_0100;
    i_mem.ram[257] = 32'h0100_0000;
    i_mem.ram[272] = 32'h0100_0000;
    i_mem.ram[128] = 32'hcafe_0001;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    chk(irq_to_cpu, irq_req);
    rdc(REG_CSW, 32'h0);
    rdc(REG_ENA, ENA_RST);
    wr(REG_BASE, 32'h1);
    acc(1'b1, REG_BASE, 32'hff, 4'h1);
    rdc(REG_BASE, 32'h1);
    foreach (rows[i])
    begin
      desc(64, rows[i].mode, rows[i].cnt, rows[i].w1);
      fire(32'h1, rows[i].nwr);
      chk(i_mem.ram[64], {rows[i].mode, rows[i].ecnt});
      chk(i_mem.ram[65], rows[i].w1);
      chk(i_mem.ram[66], rows[i].esrc);
      chk(i_mem.ram[67], rows[i].edst);
      rdc(REG_ENA, {31'h0, rows[i].eena});
      chk(irq_to_cpu[0], !rows[i].eena);
      irq_req[0] <= 1'b0;
    end
    // chain on a slow memory
    slow <= 1'b1;
    desc(64, 16'ha240, 16'h0001, 32'h0);
    desc(68, 16'ha200, 16'h0002, 32'h0);
    fire(32'h1, 8);
    chk(i_mem.ram[64][15:0], 16'h0000);
    chk(i_mem.ram[68][15:0], 16'h0001);
    rdc(REG_ENA, 32'h1);
    chk(i_mem.ram[192], 32'hcafe_0001);
    // two sources at once
    idx_q.delete();
    desc(64, 16'ha200, 16'h0005, 32'h0);
    fire(32'h6, 8);
    chk(idx_q[0], 5'h01);
    chk(idx_q[1], 5'h02);
    // software start
    wr(REG_ENA, 32'h0);
    desc(64, 16'ha200, 16'h0002, 32'h0);
    wr(REG_CSW, 32'h140);
    wait_wr(4);
    rdc(REG_CSW, 32'h040);
    chk(n_soft, 0);
    desc(64, 16'ha200, 16'h0001, 32'h0);
    wr(REG_CSW, 32'h140);
    wait_wr(4);
    chk(n_soft, 1);
    wr(REG_CSW, 32'h040);
    rdc(REG_CSW, 32'h140);
    wr(REG_CSW, 32'h040);
    rdc(REG_CSW, 32'h040);
    // abort blocks starts until cleared
    abort_event <= 1'b1;
    @(posedge clock);
    abort_event <= 1'b0;
    wr(REG_CSW, 32'h0);
    desc(64, 16'ha200, 16'h0002, 32'h0);
    wr(REG_ENA, 32'h1);
    irq_req[0] <= 1'b1;
    base_wr = i_mem.n_wr;
    repeat (30) @(posedge clock);
    chk(i_mem.n_wr, base_wr);
    rdc(REG_CSW, 32'h400);
    wr(REG_CSW, 32'h0);
    wait_wr(4);
    rdc(REG_CSW, 32'h0);
    // misaligned descriptor start
    i_mem.ram[256][31:16] = 16'h0102;
    irq_req[0] <= 1'b1;
    repeat (30) @(posedge clock);
    irq_req[0] <= 1'b0;
    rdc(REG_CSW, 32'h200);
    wr(REG_CSW, 32'h0);
    rdc(REG_CSW, 32'h0);
    chk(i_mem.hi_q, 16'h0001);
    end_sim();
  end
endmodule : event_data_transfer_ctrl_bench
`default_nettype wire
